// ==== bench/pbs_ctrl_model.sv ====
// controller-side model: drives write data two qualified edges after each write address
`timescale 1ns/10ps
module pbs_ctrl_model (
	input  wire logic               i_mclk,
	input  wire logic               i_clock_qualify_n,
	input  wire logic               i_wr_go,
	input  wire pbs_pkg::pbs_data_t i_wdata,
	output pbs_pkg::pbs_data_t      o_dq
);
	import pbs_pkg::*;

	logic      wr1_ff  = 1'b0;
	logic      wr2_ff  = 1'b0;
	pbs_data_t d1_ff   = '0;
	pbs_data_t d2_ff   = '0;
	pbs_data_t last_ff = '0;

	// ------------------------------------------------------------
	// write data pipeline
	// ------------------------------------------------------------
	// one stage per qualified edge; frozen edges stretch the data phase too
	always_ff @(posedge i_mclk) begin
		if (!i_clock_qualify_n) begin
			wr1_ff <= i_wr_go;
			d1_ff  <= i_wdata;
			wr2_ff <= wr1_ff;
			d2_ff  <= d1_ff;
		end
	end

	// released bus never holds a stale copy, so a late sample shows up
	always_ff @(posedge i_mclk) begin
		last_ff <= o_dq;
	end

	assign o_dq = wr2_ff ? d2_ff : ~last_ff;
endmodule // pbs_ctrl_model

// ==== bench/tb_pipelined_burst_sram_port.sv ====
// self-checking bench for the pipelined burst sram port
`timescale 1ns/10ps
module tb_pipelined_burst_sram_port;
	import pbs_pkg::*;

	logic      mclk = 1'b0;
	logic      srst = 1'b1;
	logic      qn   = 1'b0;
	logic      s1n  = 1'b1;
	logic      s2   = 1'b0;
	logic      s3n  = 1'b1;
	logic      wen  = 1'b1;
	logic      adv  = 1'b0;
	logic      oen  = 1'b0;
	logic      mode = 1'b0;
	logic      wgo  = 1'b0;
	pbs_lane_t lane = 2'h3;
	pbs_addr_t addr = '0;
	pbs_data_t wd   = '0;
	pbs_data_t dq_in, dq_out;
	logic      dq_oe;
	int        bad_count = 0;
	int        n_compared = 0;
	int        cyc = 0;
	pbs_data_t mem[pbs_addr_t];
	logic      ek[2] = '{1'b0, 1'b0};
	pbs_data_t ed[2];
	pbs_addr_t bb;
	logic [1:0] bs, bn;

	always #2.5 mclk = ~mclk;

	pbs_sram_port dut (.i_mclk(mclk), .i_srst(srst), .i_clock_qualify_n(qn),
		.i_chip_select_first_n(s1n), .i_chip_select_second(s2), .i_chip_select_third_n(s3n),
		.i_write_enable_n(wen), .i_byte_lane_write_n(lane), .i_advance_or_load(adv),
		.i_output_enable_n(oen), .i_burst_order_mode(mode), .i_addr(addr),
		.i_dq_in(dq_in), .o_dq_out(dq_out), .o_dq_oe(dq_oe));

	pbs_ctrl_model mdl (.i_mclk(mclk), .i_clock_qualify_n(qn), .i_wr_go(wgo),
		.i_wdata(wd), .o_dq(dq_in));

	// ------------------------------------------------------------
	// compare and closing tasks
	// ------------------------------------------------------------
	task chk_d(input string nm, input pbs_data_t e, input pbs_data_t g);
		n_compared++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	task chk_b(input string nm, input logic e, input logic g);
		n_compared++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value %s expected %b seen %b", nm, e, g);
		end
	endtask

	task close_out;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// one port cycle: check the access two qualified edges back, then present a new one
	// brk 1..3 breaks that one chip select; q high freezes the port
	task step(input logic q, input int brk, input logic w, input pbs_lane_t ln,
		input logic a, input pbs_addr_t ad, input pbs_data_t d);
		logic      rd;
		pbs_addr_t ea;
		@(negedge mclk);
		if (!q) begin
			if (ek[1]) begin
				chk_d("read data", ed[1], dq_out);
				chk_b("drive on", 1'b1, dq_oe);
				oen = 1'b1;
				#1 chk_b("drive gated", 1'b0, dq_oe);
				oen = 1'b0;
			end else
				chk_b("drive off", 1'b0, dq_oe);
			ek[1] = ek[0];
			ed[1] = ed[0];
		end
		rd = 1'b0;
		ea = ad;
		if (!q && brk == 0) begin
			if (a) begin
				bn = bn + 2'h1;
				ea = {bb[17:2], mode ? (bs ^ bn) : (bs + bn)};
				rd = 1'b1;
			end else if (!w) begin
				for (int j = 0; j < LANE_N; j++)
					if (!ln[j]) mem[ad][j*LANE_W +: LANE_W] = d[j*LANE_W +: LANE_W];
			end else begin
				bb = ad;
				bs = ad[1:0];
				bn = 2'h0;
				rd = 1'b1;
			end
		end
		if (!q) begin
			ek[0] = rd;
			ed[0] = rd ? mem[ea] : '0;
		end
		qn = q;
		s1n = (brk == 1);
		s2 = (brk != 2);
		s3n = (brk == 3);
		wen = w;
		lane = ln;
		adv = a;
		addr = ad;
		wd = d;
		wgo = !w && !a;
		@(posedge mclk);
	endtask

	task restart(input logic m);
		@(negedge mclk);
		srst = 1'b1;
		mode = m;
		repeat (3) @(posedge mclk);
		@(negedge mclk);
		srst = 1'b0;
		ek = '{1'b0, 1'b0};
		chk_d("reset data", '0, dq_out);
		chk_b("reset drive", 1'b0, dq_oe);
	endtask

	// hang guard: the whole sequence needs well under a hundred cycles
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 400) begin
			bad_count++;
			close_out();
		end
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (3) @(posedge mclk);
		@(negedge mclk);
		srst = 1'b0;
		chk_d("reset data", '0, dq_out);
		chk_b("reset drive", 1'b0, dq_oe);
		for (int i = 0; i < 4; i++)
			step(0, 0, 0, 2'h0, 0, 18'h00010 + 18'(i), pbs_data_t'(18'h15a5a + 18'h0c3c3 * i));
		step(0, 0, 0, 2'h0, 0, 18'h3ffff, 18'h2b4d3);
		step(0, 0, 1, 2'h3, 0, 18'h00011, '0);
		for (int i = 0; i < 3; i++)
			step(0, 0, 1, 2'h3, 1, '0, '0);
		step(0, 0, 0, 2'h0, 0, 18'h00020, 18'h3c3c3);
		step(0, 0, 1, 2'h3, 0, 18'h3ffff, '0);
		step(0, 0, 0, 2'h2, 0, 18'h00020, 18'h01234);
		step(0, 0, 1, 2'h3, 0, 18'h00013, '0);
		step(0, 0, 0, 2'h3, 0, 18'h00020, 18'h3ffff);
		step(0, 0, 1, 2'h3, 0, 18'h00020, '0);
		for (int b = 1; b < 4; b++) begin
			step(0, b, 0, 2'h0, 0, 18'h00010, 18'h3ffff);
			step(0, b, 1, 2'h3, 0, 18'h00011, '0);
			step(0, 0, 1, 2'h3, 0, 18'h00010, '0);
		end
		step(0, 0, 1, 2'h3, 0, 18'h00012, '0);
		for (int i = 0; i < 3; i++)
			step(1, 0, 0, 2'h0, 0, 18'h00012, 18'h00000);
		step(0, 0, 1, 2'h3, 0, 18'h00012, '0);
		step(0, 1, 1, 2'h3, 0, '0, '0);
		step(0, 1, 1, 2'h3, 0, '0, '0);
		restart(1'b1);
		step(0, 0, 1, 2'h3, 0, 18'h00011, '0);
		for (int i = 0; i < 3; i++)
			step(0, 0, 1, 2'h3, 1, '0, '0);
		step(0, 1, 1, 2'h3, 0, '0, '0);
		step(0, 1, 1, 2'h3, 0, '0, '0);
		close_out();
	end
endmodule // tb_pipelined_burst_sram_port

// ==== hdl/pbs_burst_ctr.sv ====
// two-bit burst counter with linear or interleaved order
`timescale 1ns/10ps
module pbs_burst_ctr (
	input  wire logic       i_mclk,
	input  wire logic       i_srst,
	input  wire logic       i_mode,
	input  wire logic       i_load,
	input  wire logic       i_adv,
	input  wire logic [1:0] i_seed,
	output logic [1:0]      o_low
);
	import pbs_pkg::*;

	logic       mode_ff;
	logic [1:0] seed_ff;
	logic [1:0] cnt_ff;
	logic [1:0] step;

	// strap caught while reset is held; low means linear
	always_ff @(posedge i_mclk) begin
		if (i_srst)
			mode_ff <= i_mode;
	end

	assign step = cnt_ff + 2'h1;

	// low address bits for the access decoded this cycle
	always_comb begin
		if (i_load)
			o_low = i_seed;
		else if (mode_ff)
			o_low = seed_ff ^ step;
		else
			o_low = 2'(seed_ff + step);
	end

	// seed and offset only move on qualified edges
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			seed_ff <= SEED_RST;
			cnt_ff  <= SEED_RST;
		end else if (i_load) begin
			seed_ff <= i_seed;
			cnt_ff  <= SEED_RST;
		end else if (i_adv) begin
			cnt_ff  <= step;
		end
	end
endmodule // pbs_burst_ctr

// ==== hdl/pbs_fifo.sv ====
// write queue between the port pipeline and the self-timed array writer
`timescale 1ns/10ps
module pbs_fifo #(
	parameter int WIDTH = 38,
	parameter int DEPTH = 8,
	parameter int PTR_W = 3
) (
	input  wire logic                   i_mclk,
	input  wire logic                   i_srst,
	input  wire logic                   i_valid,
	output logic                        o_ready,
	input  wire logic [WIDTH-1:0]       i_data,
	output logic                        o_valid,
	input  wire logic                   i_ready,
	output logic [WIDTH-1:0]            o_data,
	output logic                        o_full,
	output logic [DEPTH*WIDTH-1:0]      o_entries,
	output logic [DEPTH-1:0]            o_live
);
	logic [WIDTH-1:0] store [0:DEPTH-1];
	logic [PTR_W-1:0] wr_ptr_ff;
	logic [PTR_W-1:0] rd_ptr_ff;
	logic [PTR_W:0]   count_ff;
	logic             push;
	logic             pop;

	// handshakes; a pop frees a slot in the same cycle
	assign o_full  = (count_ff == (PTR_W+1)'(DEPTH));
	assign o_valid = (count_ff != '0);
	assign o_ready = !o_full || i_ready;
	assign pop     = o_valid && i_ready;
	assign push    = i_valid && o_ready;
	assign o_data  = store[rd_ptr_ff];

	// pointers and fill level
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff  <= '0;
		end else begin
			if (push)
				wr_ptr_ff <= wr_ptr_ff + 1'b1;
			if (pop)
				rd_ptr_ff <= rd_ptr_ff + 1'b1;
			count_ff <= count_ff + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
		end
	end

	// storage, no reset needed behind the pointers
	always_ff @(posedge i_mclk) begin
		if (push)
			store[wr_ptr_ff] <= i_data;
	end

	// age-ordered view, index 0 oldest, for read forwarding
	always_comb begin
		for (int i = 0; i < DEPTH; i++) begin
			o_entries[i*WIDTH +: WIDTH] = store[rd_ptr_ff + PTR_W'(i)];
			o_live[i] = (PTR_W+1)'(i) < count_ff;
		end
	end
endmodule // pbs_fifo

// ==== hdl/pbs_pkg.sv ====
// shared constants and types of the pipelined burst sram port
package pbs_pkg;

	// ------------------------------------------------------------
	// geometry
	// ------------------------------------------------------------
	localparam int ADDR_W     = 18;           // 256K words
	localparam int DATA_W     = 18;           // two lanes of 8 data + 1 parity
	localparam int LANE_N     = 2;
	localparam int LANE_W     = 9;
	localparam int MEM_WORDS  = 262144;
	localparam int FIFO_DEPTH = 8;
	localparam int FIFO_PTR_W = 3;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 5000;       // 200 MHz
	localparam int WRITE_TIME_NS = 10;         // self-timed array write
	localparam int WRITE_CYC     = (WRITE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam logic [1:0] WCNT_LOAD = 2'(WRITE_CYC - 1);

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef logic [ADDR_W-1:0] pbs_addr_t;
	typedef logic [DATA_W-1:0] pbs_data_t;
	typedef logic [LANE_N-1:0] pbs_lane_t;

	typedef enum logic [1:0] {
		OP_IDLE  = 2'b00,
		OP_READ  = 2'b01,
		OP_WRITE = 2'b10
	} pbs_op_t;

	typedef enum logic {
		WR_IDLE = 1'b0,
		WR_BUSY = 1'b1
	} pbs_wr_state_t;

	// one sampled set of synchronous inputs
	typedef struct packed {
		logic      sel1_n;
		logic      sel2;
		logic      sel3_n;
		logic      wr_n;
		pbs_lane_t lane_n;
		logic      adv;
		pbs_addr_t addr;
	} pbs_ctrl_t;

	// one decoded access in flight
	typedef struct packed {
		pbs_op_t   op;
		pbs_lane_t lane_n;
		pbs_addr_t addr;
	} pbs_acc_t;

	// one queued write
	typedef struct packed {
		pbs_lane_t lane_n;
		pbs_addr_t addr;
		pbs_data_t data;
	} pbs_wreq_t;

	localparam int WREQ_W = $bits(pbs_wreq_t);

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam pbs_ctrl_t CTRL_RST = '{sel1_n: 1'b1, sel2: 1'b0, sel3_n: 1'b1, wr_n: 1'b1,
		lane_n: 2'h3, adv: 1'b0, addr: 18'h00000};
	localparam pbs_acc_t  ACC_RST  = '{op: OP_IDLE, lane_n: 2'h3, addr: 18'h00000};
	localparam pbs_data_t DATA_RST = 18'h00000;
	localparam logic [1:0] SEED_RST = 2'h0;

endpackage

// ==== hdl/pbs_sram_port.sv ====
// pipelined 256K x 18 burst sram port with byte writes and burst counter
`timescale 1ns/10ps

// Operation
// R01 - every synchronous input lands in an input register on the rising edge
// R02 - read data leaves through output registers loaded on the rising edge
// R03 - clock qualify high freezes everything and keeps selection unchanged; the array writer and queue pops keep running
// R04 - reads and writes mix on consecutive cycles with no idle cycles
// R05 - array writes are self-timed from the clock, no external pulse
// R06 - drivers stay off during every write data phase
// R07 - three sampled chip selects; the first one is active low
// R08 - second select active high, third active low, all three needed
// R09 - sampled address picks one of 256K eighteen-bit words
// R10 - low two address bits seed the two-bit burst counter
// R11 - burst steps in linear or interleaved order
// R12 - order strap low gives linear, high gives interleaved
// R13 - active low lane strobes write their byte only with write enable
// R14 - controller drives write enable low to start a write
// R15 - advance high on a qualified edge steps the burst counter
// R16 - advance low loads a fresh address and starts a new access
// R17 - controller should load a fresh address after a deselect
// R18 - asynchronous active low output enable gates the data drivers
// R19 - drivers off while deselected and on the first clock after it
// R20 - read data after the next edge, write data two edges after address
// R21 - bursts wrap inside the four-word group, upper bits fixed
module pbs_sram_port (
	input  wire logic                i_mclk,
	input  wire logic                i_srst,
	input  wire logic                i_clock_qualify_n,
	input  wire logic                i_chip_select_first_n,
	input  wire logic                i_chip_select_second,
	input  wire logic                i_chip_select_third_n,
	input  wire logic                i_write_enable_n,
	input  wire pbs_pkg::pbs_lane_t  i_byte_lane_write_n,
	input  wire logic                i_advance_or_load,
	input  wire logic                i_output_enable_n,
	input  wire logic                i_burst_order_mode,
	input  wire pbs_pkg::pbs_addr_t  i_addr,
	input  wire pbs_pkg::pbs_data_t  i_dq_in,
	output pbs_pkg::pbs_data_t       o_dq_out,
	output logic                     o_dq_oe
);
	import pbs_pkg::*;

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	pbs_data_t     mem [0:MEM_WORDS-1];
	pbs_ctrl_t     in_ff;
	pbs_data_t     dq_in_ff;
	pbs_acc_t      b_ff;
	pbs_acc_t      c_ff;
	pbs_acc_t      nxt_acc;
	pbs_data_t     dq_out_ff;
	pbs_data_t     nxt_out;
	logic          oe_ff;
	logic          cen_ok;
	logic          sel;
	logic          load;
	logic          adv_step;
	logic [1:0]    cur_low;
	pbs_addr_t     cur_addr;
	pbs_wreq_t     push_req;
	logic          push_valid;
	logic          push_ready;
	logic          push;
	pbs_wreq_t     pop_req;
	logic [WREQ_W-1:0] pop_bits;
	logic          pop_valid;
	logic          pop_ready;
	logic          pop;
	logic          fifo_full;
	logic [FIFO_DEPTH*WREQ_W-1:0] fifo_entries;
	logic [FIFO_DEPTH-1:0]        fifo_live;
	pbs_wreq_t     ent;
	pbs_data_t     rd_word;
	pbs_wr_state_t wr_state_ff;
	logic [1:0]    wcnt_ff;

	// merge the enabled lanes of a queued write over a word
	function automatic pbs_data_t lane_merge(input pbs_data_t base, input pbs_wreq_t w);
		pbs_data_t m;
		m = base;
		for (int l = 0; l < LANE_N; l++) begin
			if (!w.lane_n[l])
				m[l*LANE_W +: LANE_W] = w.data[l*LANE_W +: LANE_W];
		end
		return m;
	endfunction

	// ------------------------------------------------------------
	// input registers
	// ------------------------------------------------------------
	// a high qualify masks the edge for the port pipeline; the array writer and queue pops keep moving
	assign cen_ok = !i_clock_qualify_n; // R03

	// control and address capture; reset parks the port deselected
	always_ff @(posedge i_mclk) begin
		if (i_srst)
			in_ff <= CTRL_RST;
		else if (cen_ok)
			in_ff <= '{sel1_n: i_chip_select_first_n, sel2: i_chip_select_second, // R01
				sel3_n: i_chip_select_third_n, wr_n: i_write_enable_n,
				lane_n: i_byte_lane_write_n, adv: i_advance_or_load, addr: i_addr};
	end

	// data pins are sampled every qualified edge; only write phases use it
	always_ff @(posedge i_mclk) begin
		if (i_srst)
			dq_in_ff <= DATA_RST;
		else if (cen_ok)
			dq_in_ff <= i_dq_in; // R01
	end

	// ------------------------------------------------------------
	// access decode
	// ------------------------------------------------------------
	assign sel      = !in_ff.sel1_n && in_ff.sel2 && !in_ff.sel3_n; // R07 R08
	assign load     = !in_ff.adv; // R16
	assign adv_step = in_ff.adv && (b_ff.op != OP_IDLE); // R15

	// low bits from the burst counter, upper bits held for the burst
	pbs_burst_ctr u_burst (
		.i_mclk (i_mclk),
		.i_srst (i_srst),
		.i_mode (i_burst_order_mode), // R12
		.i_load (cen_ok && load && sel),
		.i_adv  (cen_ok && adv_step),
		.i_seed (in_ff.addr[1:0]), // R10
		.o_low  (cur_low)
	);

	// the group stays fixed; only the counter bits move
	assign cur_addr = load ? in_ff.addr : {b_ff.addr[ADDR_W-1:2], cur_low}; // R09 R11 R21

	// a load picks read or write; an advance repeats the burst's type
	always_comb begin
		nxt_acc = ACC_RST;
		if (load) begin
			if (sel) begin
				nxt_acc.op   = in_ff.wr_n ? OP_READ : OP_WRITE; // R16
				nxt_acc.addr = cur_addr;
			end
		end else if (adv_step) begin
			nxt_acc.op   = b_ff.op; // R15
			nxt_acc.addr = cur_addr;
		end
		nxt_acc.lane_n = in_ff.lane_n; // R13
	end

	// b holds the access now on the bus, c the one whose data just arrived
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			b_ff <= ACC_RST;
			c_ff <= ACC_RST;
		end else if (cen_ok) begin
			b_ff <= nxt_acc; // R04
			c_ff <= b_ff; // R20
		end
	end

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	// queued and arriving writes override the array, newest last
	always_comb begin
		ent     = '0;
		rd_word = mem[cur_addr];
		for (int i = 0; i < FIFO_DEPTH; i++) begin
			ent = pbs_wreq_t'(fifo_entries[i*WREQ_W +: WREQ_W]);
			if (fifo_live[i] && ent.addr == cur_addr)
				rd_word = lane_merge(rd_word, ent);
		end
		if (push && push_req.addr == cur_addr)
			rd_word = lane_merge(rd_word, push_req);
	end

	// a write addressed one edge before a read of the same word is not
	// forwarded: its data lands on the same edge the read data is loaded
	assign nxt_out = (nxt_acc.op == OP_READ) ? rd_word : dq_out_ff;

	// output data register; holds across write and idle cycles
	always_ff @(posedge i_mclk) begin
		if (i_srst)
			dq_out_ff <= DATA_RST;
		else if (cen_ok)
			dq_out_ff <= nxt_out; // R02 R20
	end

	// drive only in a read data phase; a write phase or a deselect turns
	// the drivers off, and the first cycle after a deselect has no read yet
	always_ff @(posedge i_mclk) begin
		if (i_srst)
			oe_ff <= 1'b0;
		else if (cen_ok)
			oe_ff <= (nxt_acc.op == OP_READ); // R06 R19
	end

	assign o_dq_out = dq_out_ff;
	// enable pin acts without the clock, so it is gated after the flop
	assign o_dq_oe  = oe_ff && !i_output_enable_n; // R18

	// ------------------------------------------------------------
	// write path
	// ------------------------------------------------------------
	// write data taken two edges after its address, then queued
	assign push_req   = '{lane_n: c_ff.lane_n, addr: c_ff.addr, data: dq_in_ff}; // R20
	assign push_valid = cen_ok && (c_ff.op == OP_WRITE) && (c_ff.lane_n != 2'h3); // R13
	assign push       = push_valid && push_ready;

	pbs_fifo #(
		.WIDTH (WREQ_W),
		.DEPTH (FIFO_DEPTH),
		.PTR_W (FIFO_PTR_W)
	) u_wq (
		.i_mclk    (i_mclk),
		.i_srst    (i_srst),
		.i_valid   (push_valid),
		.o_ready   (push_ready),
		.i_data    (push_req),
		.o_valid   (pop_valid),
		.i_ready   (pop_ready),
		.o_data    (pop_bits),
		.o_full    (fifo_full),
		.o_entries (fifo_entries),
		.o_live    (fifo_live)
	);

	assign pop_req = pbs_wreq_t'(pop_bits);
	// a full queue commits at once so the port never has to wait
	assign pop_ready = ((wr_state_ff == WR_BUSY) && (wcnt_ff == 2'h0)) || fifo_full; // R04 R05
	assign pop       = pop_valid && pop_ready;

	// self-timed writer: paced by the clock, ignores the qualify pin
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			wr_state_ff <= WR_IDLE;
			wcnt_ff     <= 2'h0;
		end else begin
			case (wr_state_ff)
			WR_IDLE: begin
				if (pop_valid && !pop) begin
					wr_state_ff <= WR_BUSY; // R05
					wcnt_ff     <= WCNT_LOAD;
				end
			end
			WR_BUSY: begin
				if (pop)
					wr_state_ff <= WR_IDLE;
				else
					wcnt_ff <= wcnt_ff - 2'h1;
			end
			default: begin
				wr_state_ff <= WR_IDLE;
			end
			endcase
		end
	end

	// array commit, lane by lane
	always_ff @(posedge i_mclk) begin
		if (pop) begin
			for (int l = 0; l < LANE_N; l++) begin
				if (!pop_req.lane_n[l])
					mem[pop_req.addr][l*LANE_W +: LANE_W] <= pop_req.data[l*LANE_W +: LANE_W]; // R13
			end
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_srst);

	a_input_capture: assert property (cen_ok |=> in_ff.addr == $past(i_addr)) // R01
		else $error("address not captured on qualified edge");
	a_read_pipe: assert property ((cen_ok && nxt_acc.op == OP_READ) |=> // R02
		(oe_ff && dq_out_ff == $past(rd_word)))
		else $error("read data not loaded one edge later");
	a_suspend_hold: assert property (!cen_ok |=> ($stable(dq_out_ff) && $stable(b_ff) // R03
		&& $stable(oe_ff)))
		else $error("state moved while clock qualify high");
	a_write_tristate: assert property ((cen_ok && load && sel && !in_ff.wr_n) |=> !o_dq_oe) // R06
		else $error("drivers on in write data phase");
	a_desel_tristate: assert property ((cen_ok && load && !sel) |=> !o_dq_oe) // R19
		else $error("drivers on while deselected");
	a_async_oe: assert property (i_output_enable_n |-> !o_dq_oe) // R18
		else $error("output enable high but drivers on");
	a_load_addr: assert property ((cen_ok && load && sel) |=> b_ff.addr == $past(in_ff.addr)) // R16
		else $error("loaded address differs");
	a_burst_wrap: assert property ((cen_ok && adv_step) |=> // R21
		(b_ff.addr[ADDR_W-1:2] == $past(b_ff.addr[ADDR_W-1:2]) && b_ff.op == $past(b_ff.op)))
		else $error("burst left its four-word group");
	a_write_push: assert property ((cen_ok && nxt_acc.op == OP_WRITE && nxt_acc.lane_n != 2'h3) // R20
		##1 cen_ok [*2] |-> push)
		else $error("write data not queued two edges after address");

	c_read:  cover property (cen_ok && nxt_acc.op == OP_READ ##1 o_dq_oe);
	c_write: cover property (push);
	c_burst: cover property (cen_ok && adv_step [*3]);
	c_full:  cover property (fifo_full);
endmodule // pbs_sram_port
